// File: core/op_exec_pkg.sv
`default_nettype none
package op_exec_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 7;
	localparam int PC_W = 13;
	localparam int TARGET_W = 11;
	localparam int LATCH_W = 8;
	localparam int LATCH_LO = 3;
	localparam int LATCH_HI = 4;
	localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
	localparam logic [DATA_W-1:0] ONE_BYTE = 8'h01;
	localparam logic [PC_W-1:0] PC_ONE = 13'h0001;
	localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
	localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
	localparam logic DEST_ACC = 1'b0;
	localparam logic DEST_REG = 1'b1;

	typedef enum logic [6:0] {
		OP_NONE = 7'h00,
		OP_KICK = 7'h01,
		OP_CALL = 7'h02,
		OP_INVERT = 7'h04,
		OP_ZERO_REG = 7'h08,
		OP_ZERO_ACC = 7'h10,
		OP_DEC = 7'h20,
		OP_DEC_SKIP = 7'h40
	} op_t;

	typedef enum logic [2:0] {
		ST_EXEC = 3'b001,
		ST_CALL2 = 3'b010,
		ST_FLUSH = 3'b100
	} state_t;
endpackage : op_exec_pkg
`default_nettype wire

// File: core/op_alu.sv
`default_nettype none
module op_alu (
	input wire op_exec_pkg::op_t op,
	input wire logic [op_exec_pkg::DATA_W-1:0] operand,
	output logic [op_exec_pkg::DATA_W-1:0] result,
	output logic result_zero
);
	import op_exec_pkg::*;
	always_comb begin
		result = ZERO_BYTE;
		case (op)
			OP_INVERT: result = ~operand;
			OP_DEC, OP_DEC_SKIP: result = operand - ONE_BYTE;
			default: result = ZERO_BYTE;
		endcase
		result_zero = (result == ZERO_BYTE);
	end
endmodule : op_alu
`default_nettype wire

// File: core/op_execute.sv
// How it works
// - kick clears watchdog counter with a one-cycle clear pulse.
// - kick sets timeout and sleep status bits; others untouched.
// - call pushes pc plus one onto the stack on the same edge that loads the target.
// - call loads 11-bit target into pc bits 10..0.
// - call fills pc bits 12..11 from latch bits 4..3.
// - call takes two cycles, status flags unchanged.
// - invert register, result to accumulator or register by destination; zero flag updated.
// - clear addressed register, set zero flag.
// - clear accumulator, set zero flag.
// - decrement register, routed by destination; zero flag updated.
// - decrement-skip routes like decrement, no flags touched.
// - decrement-skip zero result discards next instruction as a nop.
//
// The implementer's own choices: the address map and the address-and-strobe port.
`default_nettype none
module op_execute (
	input wire logic CLK,
	input wire logic NRST,
	input wire op_exec_pkg::op_t OP,
	input wire logic OP_VALID,
	input wire logic [op_exec_pkg::ADDR_W-1:0] FILE_ADDR,
	input wire logic DEST,
	input wire logic [op_exec_pkg::TARGET_W-1:0] TARGET,
	input wire logic [op_exec_pkg::DATA_W-1:0] FILE_RDATA,
	input wire logic [op_exec_pkg::LATCH_W-1:0] PC_LATCH,
	output logic [op_exec_pkg::ADDR_W-1:0] FILE_WADDR,
	output logic [op_exec_pkg::DATA_W-1:0] FILE_WDATA,
	output logic FILE_WE,
	output logic [op_exec_pkg::DATA_W-1:0] ACC,
	output logic [op_exec_pkg::PC_W-1:0] PC,
	output logic [op_exec_pkg::PC_W-1:0] STACK_TOP,
	output logic STACK_PUSH,
	output logic WATCHDOG_CLEAR,
	output logic ZERO_FLAG,
	output logic TIMEOUT_N,
	output logic SLEEP_N,
	output logic BUSY
);
	import op_exec_pkg::*;
	typedef struct packed {
		state_t st;
		logic [PC_W-1:0] pc;
		logic [DATA_W-1:0] acc;
		logic zf;
		logic timeout_n;
		logic sleep_n;
		logic wd_clr;
		logic push;
		logic [PC_W-1:0] ret_addr;
		logic fwe;
		logic [ADDR_W-1:0] fwa;
		logic [DATA_W-1:0] fwd;
	} regs_t;

	regs_t r_q, r_d;
	logic [DATA_W-1:0] alu_res;
	logic alu_zero;
	logic take;

	op_alu u_alu (
		.op(OP),
		.operand(FILE_RDATA),
		.result(alu_res),
		.result_zero(alu_zero)
	);

	// instructions offered during the second cycle of call or a flush are not taken
	assign take = OP_VALID && (r_q.st == ST_EXEC);

	always_comb begin
		r_d = r_q;
		r_d.wd_clr = 1'b0;
		r_d.push = 1'b0;
		r_d.fwe = 1'b0;
		case (r_q.st)
			ST_CALL2: r_d.st = ST_EXEC;
			ST_FLUSH: begin
				r_d.st = ST_EXEC;
				r_d.pc = r_q.pc + PC_ONE;
			end
			default: begin
				r_d.st = ST_EXEC;
				if (take) begin
					r_d.pc = r_q.pc + PC_ONE;
					case (OP)
						OP_KICK: begin
							r_d.wd_clr = 1'b1;
							r_d.timeout_n = 1'b1;
							r_d.sleep_n = 1'b1;
						end
						OP_CALL: begin
							r_d.ret_addr = r_q.pc + PC_ONE;
							r_d.push = 1'b1;
							r_d.pc = {PC_LATCH[LATCH_HI:LATCH_LO], TARGET};
							r_d.st = ST_CALL2;
						end
						OP_ZERO_REG: begin
							r_d.fwe = 1'b1;
							r_d.fwa = FILE_ADDR;
							r_d.fwd = ZERO_BYTE;
							r_d.zf = 1'b1;
						end
						OP_ZERO_ACC: begin
							r_d.acc = ZERO_BYTE;
							r_d.zf = 1'b1;
						end
						OP_INVERT, OP_DEC, OP_DEC_SKIP: begin
							if (DEST == DEST_REG) begin
								r_d.fwe = 1'b1;
								r_d.fwa = FILE_ADDR;
								r_d.fwd = alu_res;
							end else begin
								r_d.acc = alu_res;
							end
							if (OP != OP_DEC_SKIP) begin
								r_d.zf = alu_zero;
							end
							if (OP == OP_DEC_SKIP && alu_zero) begin
								r_d.st = ST_FLUSH;
							end
						end
						default: r_d.st = ST_EXEC;
					endcase
				end
			end
		endcase
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			r_q <= '{st: ST_EXEC, pc: PC_RESET, acc: ACC_RESET, zf: 1'b0,
				timeout_n: 1'b1, sleep_n: 1'b1, wd_clr: 1'b0, push: 1'b0,
				ret_addr: PC_RESET, fwe: 1'b0, fwa: '0, fwd: ZERO_BYTE};
		end else begin
			r_q <= r_d;
		end
	end

	assign FILE_WADDR = r_q.fwa;
	assign FILE_WDATA = r_q.fwd;
	assign FILE_WE = r_q.fwe;
	assign ACC = r_q.acc;
	assign PC = r_q.pc;
	assign STACK_TOP = r_q.ret_addr;
	assign STACK_PUSH = r_q.push;
	assign WATCHDOG_CLEAR = r_q.wd_clr;
	assign ZERO_FLAG = r_q.zf;
	assign TIMEOUT_N = r_q.timeout_n;
	assign SLEEP_N = r_q.sleep_n;
	// busy tells the fetcher the offered instruction is not taken this cycle
	assign BUSY = (r_q.st != ST_EXEC);

	property p_kick;
		@(posedge CLK) disable iff (!NRST)
		(take && OP == OP_KICK) |=> (WATCHDOG_CLEAR && TIMEOUT_N && SLEEP_N && $stable(ZERO_FLAG));
	endproperty
	a_kick: assert property (p_kick) else $error("kick did not clear watchdog");

	property p_kick_pulse;
		@(posedge CLK) disable iff (!NRST)
		(take && OP == OP_KICK) |=> ##1 !WATCHDOG_CLEAR || $past(take && OP == OP_KICK);
	endproperty
	a_kick_pulse: assert property (p_kick_pulse) else $error("watchdog clear not a pulse");

	sequence s_call;
		take && OP == OP_CALL;
	endsequence

	property p_call_push;
		@(posedge CLK) disable iff (!NRST)
		s_call |=> (STACK_PUSH && STACK_TOP == $past(PC) + PC_ONE);
	endproperty
	a_call_push: assert property (p_call_push) else $error("call return address wrong");

	property p_call_target;
		@(posedge CLK) disable iff (!NRST)
		s_call |=> PC == {$past(PC_LATCH[LATCH_HI:LATCH_LO]), $past(TARGET)};
	endproperty
	a_call_target: assert property (p_call_target) else $error("call target wrong");

	property p_call_two;
		@(posedge CLK) disable iff (!NRST)
		s_call |=> BUSY ##1 (!BUSY && $stable(ZERO_FLAG));
	endproperty
	a_call_two: assert property (p_call_two) else $error("call not two cycles");

	property p_zero_acc;
		@(posedge CLK) disable iff (!NRST)
		(take && OP == OP_ZERO_ACC) |=> (ACC == ZERO_BYTE && ZERO_FLAG);
	endproperty
	a_zero_acc: assert property (p_zero_acc) else $error("accumulator not cleared");

	property p_zero_reg;
		@(posedge CLK) disable iff (!NRST)
		(take && OP == OP_ZERO_REG) |=> (FILE_WE && FILE_WDATA == ZERO_BYTE && ZERO_FLAG);
	endproperty
	a_zero_reg: assert property (p_zero_reg) else $error("register not cleared");

	property p_invert;
		@(posedge CLK) disable iff (!NRST)
		(take && OP == OP_INVERT && DEST == DEST_ACC) |=> ACC == ~$past(FILE_RDATA);
	endproperty
	a_invert: assert property (p_invert) else $error("invert result wrong");

	property p_dec_flag;
		@(posedge CLK) disable iff (!NRST)
		(take && OP == OP_DEC) |=> ZERO_FLAG == ($past(FILE_RDATA) == ONE_BYTE);
	endproperty
	a_dec_flag: assert property (p_dec_flag) else $error("decrement zero flag wrong");

	property p_dec_reg;
		@(posedge CLK) disable iff (!NRST)
		(take && OP == OP_DEC && DEST == DEST_REG) |=> FILE_WDATA == $past(FILE_RDATA) - ONE_BYTE;
	endproperty
	a_dec_reg: assert property (p_dec_reg) else $error("decrement write wrong");

	property p_skip_flags;
		@(posedge CLK) disable iff (!NRST)
		(take && OP == OP_DEC_SKIP) |=> $stable(ZERO_FLAG);
	endproperty
	a_skip_flags: assert property (p_skip_flags) else $error("skip touched flags");

	property p_skip;
		@(posedge CLK) disable iff (!NRST)
		(take && OP == OP_DEC_SKIP) |=> BUSY == ($past(FILE_RDATA) == ONE_BYTE);
	endproperty
	a_skip: assert property (p_skip) else $error("skip decision wrong");

	sequence s_skip_zero;
		take && OP == OP_DEC_SKIP && FILE_RDATA == ONE_BYTE;
	endsequence

	// the flush cycle must still step the counter, or the fetcher re-runs the dropped op
	property p_skip_pc;
		@(posedge CLK) disable iff (!NRST)
		s_skip_zero |=> BUSY ##1 (!BUSY && PC == $past(PC) + PC_ONE);
	endproperty
	a_skip_pc: assert property (p_skip_pc) else $error("skip did not step past next op");

	property p_skip_acc;
		@(posedge CLK) disable iff (!NRST)
		(take && OP == OP_DEC_SKIP && DEST == DEST_ACC) |=>
			(ACC == $past(FILE_RDATA) - ONE_BYTE && !FILE_WE);
	endproperty
	a_skip_acc: assert property (p_skip_acc) else $error("skip accumulator result wrong");

	property p_skip_reg;
		@(posedge CLK) disable iff (!NRST)
		(take && OP == OP_DEC_SKIP && DEST == DEST_REG) |=> (FILE_WE &&
			FILE_WADDR == $past(FILE_ADDR) && FILE_WDATA == $past(FILE_RDATA) - ONE_BYTE);
	endproperty
	a_skip_reg: assert property (p_skip_reg) else $error("skip register write wrong");

	property p_invert_reg;
		@(posedge CLK) disable iff (!NRST)
		(take && OP == OP_INVERT && DEST == DEST_REG) |=>
			(FILE_WE && FILE_WADDR == $past(FILE_ADDR) && FILE_WDATA == ~$past(FILE_RDATA));
	endproperty
	a_invert_reg: assert property (p_invert_reg) else $error("invert write wrong");

	property p_invert_flag;
		@(posedge CLK) disable iff (!NRST)
		(take && OP == OP_INVERT) |=> ZERO_FLAG == ($past(FILE_RDATA) == ~ZERO_BYTE);
	endproperty
	a_invert_flag: assert property (p_invert_flag) else $error("invert zero flag wrong");

	property p_dec_acc;
		@(posedge CLK) disable iff (!NRST)
		(take && OP == OP_DEC && DEST == DEST_ACC) |=>
			(ACC == $past(FILE_RDATA) - ONE_BYTE && !FILE_WE);
	endproperty
	a_dec_acc: assert property (p_dec_acc) else $error("decrement accumulator wrong");

	property p_call_high;
		@(posedge CLK) disable iff (!NRST)
		s_call |=> PC[PC_W-1:TARGET_W] == $past(PC_LATCH[LATCH_HI:LATCH_LO]);
	endproperty
	a_call_high: assert property (p_call_high) else $error("call upper bits wrong");

	property p_call_flags;
		@(posedge CLK) disable iff (!NRST)
		s_call |=> ($stable(ZERO_FLAG) && $stable(TIMEOUT_N) && $stable(SLEEP_N));
	endproperty
	a_call_flags: assert property (p_call_flags) else $error("call touched flags");

	// a stray push would corrupt the return stack, so it must trace back to a taken call
	property p_push_only;
		@(posedge CLK) disable iff (!NRST)
		STACK_PUSH |-> $past(take && OP == OP_CALL);
	endproperty
	a_push_only: assert property (p_push_only) else $error("push without call");

	property p_kick_only;
		@(posedge CLK) disable iff (!NRST)
		WATCHDOG_CLEAR |-> $past(take && OP == OP_KICK);
	endproperty
	a_kick_only: assert property (p_kick_only) else $error("watchdog clear without kick");

	property p_kick_quiet;
		@(posedge CLK) disable iff (!NRST)
		(take && OP == OP_KICK) |=> (!FILE_WE && !STACK_PUSH && $stable(ACC));
	endproperty
	a_kick_quiet: assert property (p_kick_quiet) else $error("kick touched other state");

	// while busy the offered op is dropped: nothing may change but the counter
	property p_busy_refuse;
		@(posedge CLK) disable iff (!NRST)
		BUSY |=> (!FILE_WE && !STACK_PUSH && !WATCHDOG_CLEAR &&
			$stable(ACC) && $stable(ZERO_FLAG));
	endproperty
	a_busy_refuse: assert property (p_busy_refuse) else $error("op taken while busy");
endmodule : op_execute
`default_nettype wire

// File: test/regfile_model.sv
`default_nettype none
module regfile_model (
	input wire logic CLK,
	input wire logic NRST,
	input wire logic [op_exec_pkg::ADDR_W-1:0] RADDR,
	output logic [op_exec_pkg::DATA_W-1:0] RDATA,
	input wire logic [op_exec_pkg::ADDR_W-1:0] WADDR,
	input wire logic [op_exec_pkg::DATA_W-1:0] WDATA,
	input wire logic WE,
	input wire logic PUSH,
	input wire logic [op_exec_pkg::PC_W-1:0] TOP,
	output logic [op_exec_pkg::PC_W-1:0] RET,
	input wire logic WATCHDOG_CLEAR,
	output logic [7:0] WD_COUNT
);
	timeunit 1ns;
	timeprecision 1ps;
	import op_exec_pkg::*;
	logic [DATA_W-1:0] mem [128];
	// each register starts out holding its own address
	initial begin
		for (int i = 0; i < 128; i++) begin
			mem[i] = 8'(i);
		end
	end
	assign RDATA = mem[RADDR];
	always @(posedge CLK) begin
		if (WE) begin
			mem[WADDR] <= WDATA;
		end
	end
	// free running, so a clear shows as a drop to zero
	always @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			WD_COUNT <= 8'h00;
			RET <= '0;
		end else begin
			WD_COUNT <= WATCHDOG_CLEAR ? 8'h00 : WD_COUNT + 8'h01;
			if (PUSH) begin
				RET <= TOP;
			end
		end
	end
endmodule : regfile_model
`default_nettype wire

// File: test/tb_core_op_execute_subset.sv
`default_nettype none
module tb_core_op_execute_subset;
	timeunit 1ns;
	timeprecision 1ps;
	import op_exec_pkg::*;
	logic CLK = 1'b0, NRST = 1'b0, OP_VALID = 1'b0, DEST = 1'b0;
	op_t OP = OP_NONE;
	logic [ADDR_W-1:0] FILE_ADDR = '0, FILE_WADDR;
	logic [TARGET_W-1:0] TARGET = '0;
	logic [LATCH_W-1:0] PC_LATCH = '0;
	logic [DATA_W-1:0] FILE_RDATA, FILE_WDATA, ACC;
	logic [PC_W-1:0] PC, STACK_TOP, ret, exp_pc, top;
	logic FILE_WE, STACK_PUSH, WATCHDOG_CLEAR, ZERO_FLAG, TIMEOUT_N, SLEEP_N, BUSY;
	logic [7:0] wd_count;
	logic [LATCH_W-1:0] latch = '0;
	int n_fail = 0;
	int num_checks = 0;
	always #10 CLK = ~CLK;
	op_execute DUT (.CLK(CLK), .NRST(NRST), .OP(OP), .OP_VALID(OP_VALID),
		.FILE_ADDR(FILE_ADDR), .DEST(DEST), .TARGET(TARGET), .FILE_RDATA(FILE_RDATA),
		.PC_LATCH(PC_LATCH), .FILE_WADDR(FILE_WADDR), .FILE_WDATA(FILE_WDATA),
		.FILE_WE(FILE_WE), .ACC(ACC), .PC(PC), .STACK_TOP(STACK_TOP),
		.STACK_PUSH(STACK_PUSH), .WATCHDOG_CLEAR(WATCHDOG_CLEAR), .ZERO_FLAG(ZERO_FLAG),
		.TIMEOUT_N(TIMEOUT_N), .SLEEP_N(SLEEP_N), .BUSY(BUSY));
	regfile_model pm (.CLK(CLK), .NRST(NRST), .RADDR(FILE_ADDR), .RDATA(FILE_RDATA),
		.WADDR(FILE_WADDR), .WDATA(FILE_WDATA), .WE(FILE_WE), .PUSH(STACK_PUSH),
		.TOP(STACK_TOP), .RET(ret), .WATCHDOG_CLEAR(WATCHDOG_CLEAR), .WD_COUNT(wd_count));
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : wrap_up
	task automatic go(input op_t op, input logic [6:0] a, input logic d,
		input logic [10:0] t, input logic hold);
		@(posedge CLK);
		OP <= op;
		FILE_ADDR <= a;
		DEST <= d;
		TARGET <= t;
		PC_LATCH <= latch;
		OP_VALID <= 1'b1;
		@(posedge CLK);
		OP_VALID <= hold;
		// a call lands on its target, every other taken op steps the counter
		exp_pc = (op == OP_CALL) ? {latch[LATCH_HI:LATCH_LO], t} : exp_pc + PC_ONE;
		#1;
		chk("pc", PC, exp_pc);
	endtask : go
	// the held request lands while busy and must be dropped
	task automatic refused(input logic skip);
		@(posedge CLK);
		OP_VALID <= 1'b0;
		exp_pc = exp_pc + PC_W'(skip);
		#1;
		chk("pc", PC, exp_pc);
		chk("we", FILE_WE, 1'b0);
		chk("push", STACK_PUSH, 1'b0);
		chk("busy", BUSY, 1'b0);
	endtask : refused
	task automatic alu(input op_t op, input logic [6:0] a, input logic d,
		input logic [7:0] v, input logic z);
		go(op, a, d, 11'h000, 1'b0);
		chk("we", FILE_WE, d);
		if (d) chk("wdata", {FILE_WADDR, FILE_WDATA}, {a, v});
		else chk("acc", ACC, v);
		chk("z", ZERO_FLAG, z);
		chk("busy", BUSY, 1'b0);
	endtask : alu
	initial begin
		exp_pc = PC_RESET;
		repeat (12) @(posedge CLK);
		NRST <= 1'b1;
		#1;
		chk("rst", {PC, ACC, ZERO_FLAG, TIMEOUT_N, SLEEP_N, BUSY}, {PC_RESET, ACC_RESET, 4'h6});
		alu(OP_INVERT, 7'h7f, DEST_ACC, 8'h80, 1'b0);
		alu(OP_ZERO_REG, 7'h7f, DEST_REG, 8'h00, 1'b1);
		alu(OP_INVERT, 7'h10, DEST_REG, 8'hef, 1'b0);
		alu(OP_ZERO_ACC, 7'h00, DEST_ACC, 8'h00, 1'b1);
		alu(OP_DEC, 7'h00, DEST_REG, 8'hff, 1'b0);
		alu(OP_DEC, 7'h01, DEST_ACC, 8'h00, 1'b1);
		alu(OP_DEC_SKIP, 7'h03, DEST_REG, 8'h02, 1'b1);
		alu(OP_DEC, 7'h02, DEST_ACC, 8'h01, 1'b0);
		alu(OP_DEC_SKIP, 7'h05, DEST_ACC, 8'h04, 1'b0);
		$display("data ops done");
		go(OP_DEC_SKIP, 7'h01, DEST_REG, 11'h000, 1'b1);
		chk("wdata", {FILE_WE, FILE_WDATA, ZERO_FLAG}, {1'b1, 8'h00, 1'b0});
		chk("busy", BUSY, 1'b1);
		refused(1'b1);
		$display("skip done");
		go(OP_KICK, 7'h00, DEST_ACC, 11'h000, 1'b0);
		chk("kick", {WATCHDOG_CLEAR, TIMEOUT_N, SLEEP_N, ZERO_FLAG}, 4'he);
		refused(1'b0);
		chk("watchdog", {WATCHDOG_CLEAR, wd_count}, 9'h000);
		go(OP_NONE, 7'h00, DEST_ACC, 11'h000, 1'b0);
		$display("kick done");
		latch = 8'h18;
		top = exp_pc + PC_ONE;
		go(OP_CALL, 7'h00, DEST_ACC, 11'h7ff, 1'b1);
		exp_pc = 13'h1fff;
		chk("pc", PC, exp_pc);
		chk("push", {STACK_PUSH, STACK_TOP, BUSY}, {1'b1, top, 1'b1});
		chk("flags", {ZERO_FLAG, TIMEOUT_N, SLEEP_N}, 3'h3);
		refused(1'b0);
		chk("ret", ret, top);
		latch = 8'he7;
		go(OP_CALL, 7'h00, DEST_ACC, 11'h000, 1'b0);
		exp_pc = 13'h0000;
		chk("pc", PC, exp_pc);
		$display("call done");
		wrap_up();
	end
	initial begin
		#40000;
		n_fail++;
		wrap_up();
	end
endmodule : tb_core_op_execute_subset
`default_nettype wire
